// File: logic/ceaas_pkg.sv
/*
  Shared constants for the cell-extreme and auxiliary alert status block:
  register indices, field positions, reset values and common types.
  Assumes a register port addressed by register index, 16-bit data.
*/
`default_nettype none

package ceaas_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NUM_CELLS = 14;
  localparam int unsigned NUM_AUX = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CELL_W = 16;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned IRQ_W = 3;

  typedef logic [IDX_W-1:0] ceaas_idx_t;
  typedef logic [DATA_W-1:0] ceaas_word_t;
  typedef logic [ADDR_W-1:0] ceaas_addr_t;

  // ==========================================================
  // Register indices
  localparam ceaas_addr_t OFF_CELL_EXTREME = 8'h0A;
  localparam ceaas_addr_t OFF_AUX_PROTECT = 8'h0B;
  localparam ceaas_addr_t OFF_AUX_COLD = 8'h0C;
  localparam ceaas_addr_t OFF_CELL_ENABLE = 8'h20;
  localparam ceaas_addr_t OFF_CELL_POLARITY = 8'h21;
  localparam ceaas_addr_t OFF_SEARCH_CTRL = 8'h22;
  localparam ceaas_addr_t OFF_AUX_PIN_CFG = 8'h23;
  localparam ceaas_addr_t OFF_AUX_OV_EN = 8'h24;
  localparam ceaas_addr_t OFF_IRQ_STATUS = 8'h25;
  localparam ceaas_addr_t OFF_IRQ_MASK = 8'h26;

  // ==========================================================
  // Field positions
  localparam int unsigned HI_IDX_LSB = 8;
  localparam int unsigned LO_IDX_LSB = 0;
  localparam int unsigned FILT_SEL_BIT = 0;
  localparam int unsigned POL_SEL_BIT = 1;
  localparam int unsigned IRQ_SCAN_BIT = 0;
  localparam int unsigned IRQ_PROT_BIT = 1;
  localparam int unsigned IRQ_COLD_BIT = 2;

  // ==========================================================
  // Reset values and codes
  localparam ceaas_word_t RST_CELL_EXTREME = 16'h0000;
  localparam logic [NUM_AUX-1:0] RST_AUX_FLAGS = 4'h0;
  localparam logic [NUM_CELLS-1:0] RST_CELL_BITS = 14'h0000;
  localparam logic [1:0] RST_SEARCH_CTRL = 2'h0;
  localparam logic [NUM_AUX-1:0] RST_AUX_CFG = 4'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
  localparam ceaas_idx_t NO_RESULT_IDX = 4'hF;

endpackage : ceaas_pkg

`default_nettype wire

// File: logic/ceaas_extreme_search.sv
/*
  Combinational search for the highest and lowest enabled cell of one
  polarity set. Assumes the caller registers the results.
*/
`timescale 1ns/10ps
`default_nettype none

module ceaas_extreme_search (
  input wire logic [ceaas_pkg::NUM_CELLS*ceaas_pkg::CELL_W-1:0] cell_data,
  input wire logic [ceaas_pkg::NUM_CELLS-1:0] cell_scan_enable,
  input wire logic [ceaas_pkg::NUM_CELLS-1:0] cell_polarity,
  input wire logic extreme_search_polarity,
  output ceaas_pkg::ceaas_idx_t highest_cell_index,
  output ceaas_pkg::ceaas_idx_t lowest_cell_index
);

  // Strict compare keeps the first (lowest numbered) cell on a tie
  function automatic logic beats(
    input logic [ceaas_pkg::CELL_W-1:0] a,
    input logic [ceaas_pkg::CELL_W-1:0] b,
    input logic bipolar,
    input logic want_hi
  );
    logic gt;
    logic lt;
    if (bipolar) begin
      gt = $signed(a) > $signed(b);
      lt = $signed(a) < $signed(b);
    end else begin
      gt = a > b;
      lt = a < b;
    end
    return want_hi ? gt : lt;
  endfunction : beats

  logic hi_found;
  logic lo_found;
  logic [ceaas_pkg::CELL_W-1:0] hi_val;
  logic [ceaas_pkg::CELL_W-1:0] lo_val;
  logic [ceaas_pkg::CELL_W-1:0] v;

  always_comb begin
    hi_found = 1'b0;
    lo_found = 1'b0;
    hi_val = '0;
    lo_val = '0;
    v = '0;
    highest_cell_index = ceaas_pkg::NO_RESULT_IDX;
    lowest_cell_index = ceaas_pkg::NO_RESULT_IDX;
    for (int i = 0; i < ceaas_pkg::NUM_CELLS; i++) begin
      // Only enabled cells of the chosen set take part
      if (cell_scan_enable[i] && (cell_polarity[i] == extreme_search_polarity)) begin
        v = cell_data[i*ceaas_pkg::CELL_W +: ceaas_pkg::CELL_W];
        if (!hi_found || beats(v, hi_val, extreme_search_polarity, 1'b1)) begin
          hi_val = v;
          hi_found = 1'b1;
          highest_cell_index = ceaas_pkg::ceaas_idx_t'(i + 1);
        end
        if (!lo_found || beats(v, lo_val, extreme_search_polarity, 1'b0)) begin
          lo_val = v;
          lo_found = 1'b1;
          lowest_cell_index = ceaas_pkg::ceaas_idx_t'(i + 1);
        end
      end
    end
  end

endmodule : ceaas_extreme_search

`default_nettype wire

// File: logic/ceaas_aux_guard.sv
/*
  Auxiliary input protection faults, input switch control and cold
  overvoltage flags. Assumes retry is a one-cycle pulse given after the
  pin configuration register already holds the rewritten value.
*/
`timescale 1ns/10ps
`default_nettype none

module ceaas_aux_guard (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [ceaas_pkg::NUM_AUX-1:0] aux_pin_config,
  input wire logic [ceaas_pkg::NUM_AUX-1:0] aux_overvoltage_alert_enable,
  input wire logic retry,
  input wire logic aux_acq_done,
  input wire logic [ceaas_pkg::NUM_AUX-1:0] aux_over_rail,
  input wire logic [ceaas_pkg::NUM_AUX-1:0] aux_over_threshold,
  output logic [ceaas_pkg::NUM_AUX-1:0] aux_protection_fault_flags,
  output logic [ceaas_pkg::NUM_AUX-1:0] aux_cold_overvoltage_flags,
  output logic [ceaas_pkg::NUM_AUX-1:0] aux_switch_closed
);

  logic [ceaas_pkg::NUM_AUX-1:0] prot_d;
  logic [ceaas_pkg::NUM_AUX-1:0] cold_d;
  logic [ceaas_pkg::NUM_AUX-1:0] sw_d;

  // ==========================================================
  // Next state
  always_comb begin
    prot_d = aux_protection_fault_flags;
    cold_d = aux_cold_overvoltage_flags;
    for (int n = 0; n < ceaas_pkg::NUM_AUX; n++) begin
      if (!aux_pin_config[n]) begin
        prot_d[n] = 1'b0;
      end else if (aux_over_rail[n]) begin
        prot_d[n] = 1'b1;
      end else if (retry) begin
        prot_d[n] = 1'b0;
      end
      if (aux_acq_done) begin
        if (!(aux_pin_config[n] && aux_overvoltage_alert_enable[n])) begin
          cold_d[n] = 1'b0;
        end else if (!aux_protection_fault_flags[n]) begin
          // Faulted pin holds its flag: its reading is not trusted
          cold_d[n] = aux_over_threshold[n];
        end
      end
    end
    sw_d = aux_pin_config & ~prot_d;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aux_protection_fault_flags <= ceaas_pkg::RST_AUX_FLAGS;
      aux_cold_overvoltage_flags <= ceaas_pkg::RST_AUX_FLAGS;
      aux_switch_closed <= ceaas_pkg::RST_AUX_FLAGS;
    end else if (clk_en) begin
      aux_protection_fault_flags <= prot_d;
      aux_cold_overvoltage_flags <= cold_d;
      aux_switch_closed <= sw_d;
    end
  end

endmodule : ceaas_aux_guard

`default_nettype wire

// File: logic/ceaas_top.sv
/*
  Cell-extreme and auxiliary alert status block: register port, extreme
  cell capture, auxiliary protection and cold alert flags, interrupt.
  Assumes scan results, aux comparator levels and strobes are synchronous
  to core_clk and that strobes are one cycle wide.
*/
// The address-and-strobe port is this design's own decision.
// Contract
// - Scan loads highest enabled cell number
// - Scan loads lowest enabled cell number
// - Non-scan requests leave both fields
// - Search uses raw or filtered data
// - Ties report lowest cell number
// - Polarity setting picks unipolar or bipolar
// - Empty set reports index Fh
// - Configured aux above rail sets protection flag
// - Fault opens that pin's input switch
// - Faulted pin data and alerts invalid
// - Clear on resolved retry or unconfig
// - Any pin config write triggers retry
// - Enabled aux over threshold sets cold
// - Cold flag clears when condition gone
// - Status registers read-only, reset zero
// - Polarity bit one means bipolar
`timescale 1ns/10ps
`default_nettype none

module ceaas_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [ceaas_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ceaas_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ceaas_pkg::DATA_W-1:0] reg_rdata,
  input wire logic scan_done,
  input wire logic scan_mode,
  input wire logic [ceaas_pkg::NUM_CELLS*ceaas_pkg::CELL_W-1:0] cell_raw_data,
  input wire logic [ceaas_pkg::NUM_CELLS*ceaas_pkg::CELL_W-1:0] cell_iir_data,
  input wire logic aux_acq_done,
  input wire logic [ceaas_pkg::NUM_AUX-1:0] aux_over_rail,
  input wire logic [ceaas_pkg::NUM_AUX-1:0] aux_over_threshold,
  output logic [ceaas_pkg::NUM_AUX-1:0] aux_switch_closed,
  output logic irq
);

  // Zero-extends a narrow field into a register word
  function automatic ceaas_pkg::ceaas_word_t widen(input logic [ceaas_pkg::NUM_CELLS-1:0] f);
    return ceaas_pkg::ceaas_word_t'(f);
  endfunction : widen

  function automatic logic hit(input logic strobe, input ceaas_pkg::ceaas_addr_t a, input ceaas_pkg::ceaas_addr_t off);
    return strobe && (a == off);
  endfunction : hit

  // ==========================================================
  // Configuration registers
  logic [ceaas_pkg::NUM_CELLS-1:0] cell_scan_enable_q;
  logic [ceaas_pkg::NUM_CELLS-1:0] cell_scan_enable_d;
  logic [ceaas_pkg::NUM_CELLS-1:0] cell_polarity_q;
  logic [ceaas_pkg::NUM_CELLS-1:0] cell_polarity_d;
  logic [1:0] search_ctrl_q;
  logic [1:0] search_ctrl_d;
  logic [ceaas_pkg::NUM_AUX-1:0] aux_pin_config_q;
  logic [ceaas_pkg::NUM_AUX-1:0] aux_pin_config_d;
  logic [ceaas_pkg::NUM_AUX-1:0] aux_ov_en_q;
  logic [ceaas_pkg::NUM_AUX-1:0] aux_ov_en_d;
  logic [ceaas_pkg::IRQ_W-1:0] irq_mask_q;
  logic [ceaas_pkg::IRQ_W-1:0] irq_mask_d;
  logic retry_q;
  logic retry_d;

  always_comb begin
    cell_scan_enable_d = cell_scan_enable_q;
    cell_polarity_d = cell_polarity_q;
    search_ctrl_d = search_ctrl_q;
    aux_pin_config_d = aux_pin_config_q;
    aux_ov_en_d = aux_ov_en_q;
    irq_mask_d = irq_mask_q;
    retry_d = 1'b0;
    if (hit(reg_wr, reg_addr, ceaas_pkg::OFF_CELL_ENABLE)) begin
      cell_scan_enable_d = reg_wdata[ceaas_pkg::NUM_CELLS-1:0];
    end
    if (hit(reg_wr, reg_addr, ceaas_pkg::OFF_CELL_POLARITY)) begin
      cell_polarity_d = reg_wdata[ceaas_pkg::NUM_CELLS-1:0];
    end
    if (hit(reg_wr, reg_addr, ceaas_pkg::OFF_SEARCH_CTRL)) begin
      search_ctrl_d = reg_wdata[1:0];
    end
    if (hit(reg_wr, reg_addr, ceaas_pkg::OFF_AUX_PIN_CFG)) begin
      aux_pin_config_d = reg_wdata[ceaas_pkg::NUM_AUX-1:0];
      // Same value written still counts: that is how a retry is asked
      retry_d = 1'b1;
    end
    if (hit(reg_wr, reg_addr, ceaas_pkg::OFF_AUX_OV_EN)) begin
      aux_ov_en_d = reg_wdata[ceaas_pkg::NUM_AUX-1:0];
    end
    if (hit(reg_wr, reg_addr, ceaas_pkg::OFF_IRQ_MASK)) begin
      irq_mask_d = reg_wdata[ceaas_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cell_scan_enable_q <= ceaas_pkg::RST_CELL_BITS;
      cell_polarity_q <= ceaas_pkg::RST_CELL_BITS;
      search_ctrl_q <= ceaas_pkg::RST_SEARCH_CTRL;
      aux_pin_config_q <= ceaas_pkg::RST_AUX_CFG;
      aux_ov_en_q <= ceaas_pkg::RST_AUX_CFG;
      irq_mask_q <= ceaas_pkg::RST_IRQ;
      retry_q <= 1'b0;
    end else if (clk_en) begin
      cell_scan_enable_q <= cell_scan_enable_d;
      cell_polarity_q <= cell_polarity_d;
      search_ctrl_q <= search_ctrl_d;
      aux_pin_config_q <= aux_pin_config_d;
      aux_ov_en_q <= aux_ov_en_d;
      irq_mask_q <= irq_mask_d;
      retry_q <= retry_d;
    end
  end

  // ==========================================================
  // Extreme cell capture
  logic [ceaas_pkg::NUM_CELLS*ceaas_pkg::CELL_W-1:0] search_data;
  ceaas_pkg::ceaas_idx_t found_hi;
  ceaas_pkg::ceaas_idx_t found_lo;
  ceaas_pkg::ceaas_word_t cell_extreme_location_q;
  ceaas_pkg::ceaas_word_t cell_extreme_location_d;
  logic scan_capture;

  assign search_data = search_ctrl_q[ceaas_pkg::FILT_SEL_BIT] ? cell_iir_data : cell_raw_data;

  ceaas_extreme_search u_search (
    .cell_data(search_data),
    .cell_scan_enable(cell_scan_enable_q),
    .cell_polarity(cell_polarity_q),
    .extreme_search_polarity(search_ctrl_q[ceaas_pkg::POL_SEL_BIT]),
    .highest_cell_index(found_hi),
    .lowest_cell_index(found_lo)
  );

  assign scan_capture = scan_done && scan_mode;

  always_comb begin
    cell_extreme_location_d = cell_extreme_location_q;
    if (scan_capture) begin
      // One word write so a read never mixes two scans
      cell_extreme_location_d = '0;
      cell_extreme_location_d[ceaas_pkg::HI_IDX_LSB +: ceaas_pkg::IDX_W] = found_hi;
      cell_extreme_location_d[ceaas_pkg::LO_IDX_LSB +: ceaas_pkg::IDX_W] = found_lo;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cell_extreme_location_q <= ceaas_pkg::RST_CELL_EXTREME;
    end else if (clk_en) begin
      cell_extreme_location_q <= cell_extreme_location_d;
    end
  end

  // ==========================================================
  // Auxiliary protection and cold alerts
  logic [ceaas_pkg::NUM_AUX-1:0] aux_protection_fault_flags;
  logic [ceaas_pkg::NUM_AUX-1:0] aux_cold_overvoltage_flags;

  ceaas_aux_guard u_aux (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .aux_pin_config(aux_pin_config_q),
    .aux_overvoltage_alert_enable(aux_ov_en_q),
    .retry(retry_q),
    .aux_acq_done(aux_acq_done),
    .aux_over_rail(aux_over_rail),
    .aux_over_threshold(aux_over_threshold),
    .aux_protection_fault_flags(aux_protection_fault_flags),
    .aux_cold_overvoltage_flags(aux_cold_overvoltage_flags),
    .aux_switch_closed(aux_switch_closed)
  );

  // ==========================================================
  // Interrupt status
  logic [ceaas_pkg::NUM_AUX-1:0] prot_prev_q;
  logic [ceaas_pkg::NUM_AUX-1:0] cold_prev_q;
  logic [ceaas_pkg::IRQ_W-1:0] irq_status_q;
  logic [ceaas_pkg::IRQ_W-1:0] irq_status_d;
  logic [ceaas_pkg::IRQ_W-1:0] irq_event;
  logic [ceaas_pkg::IRQ_W-1:0] irq_clear;
  logic irq_d;

  always_comb begin
    irq_event = '0;
    irq_event[ceaas_pkg::IRQ_SCAN_BIT] = scan_capture;
    irq_event[ceaas_pkg::IRQ_PROT_BIT] = |(aux_protection_fault_flags & ~prot_prev_q);
    irq_event[ceaas_pkg::IRQ_COLD_BIT] = |(aux_cold_overvoltage_flags & ~cold_prev_q);
    irq_clear = '0;
    if (hit(reg_wr, reg_addr, ceaas_pkg::OFF_IRQ_STATUS)) begin
      irq_clear = reg_wdata[ceaas_pkg::IRQ_W-1:0];
    end
    // New event beats a clear landing in the same cycle
    irq_status_d = (irq_status_q & ~irq_clear) | irq_event;
    irq_d = |(irq_status_d & irq_mask_d);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prot_prev_q <= ceaas_pkg::RST_AUX_FLAGS;
      cold_prev_q <= ceaas_pkg::RST_AUX_FLAGS;
      irq_status_q <= ceaas_pkg::RST_IRQ;
      irq <= 1'b0;
    end else if (clk_en) begin
      prot_prev_q <= aux_protection_fault_flags;
      cold_prev_q <= aux_cold_overvoltage_flags;
      irq_status_q <= irq_status_d;
      irq <= irq_d;
    end
  end

  // ==========================================================
  // Read port
  ceaas_pkg::ceaas_word_t rdata_d;

  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        ceaas_pkg::OFF_CELL_EXTREME: begin
          rdata_d = cell_extreme_location_q;
        end
        ceaas_pkg::OFF_AUX_PROTECT: begin
          rdata_d = widen({10'h000, aux_protection_fault_flags});
        end
        ceaas_pkg::OFF_AUX_COLD: begin
          rdata_d = widen({10'h000, aux_cold_overvoltage_flags});
        end
        ceaas_pkg::OFF_CELL_ENABLE: begin
          rdata_d = widen(cell_scan_enable_q);
        end
        ceaas_pkg::OFF_CELL_POLARITY: begin
          rdata_d = widen(cell_polarity_q);
        end
        ceaas_pkg::OFF_SEARCH_CTRL: begin
          rdata_d = widen({12'h000, search_ctrl_q});
        end
        ceaas_pkg::OFF_AUX_PIN_CFG: begin
          rdata_d = widen({10'h000, aux_pin_config_q});
        end
        ceaas_pkg::OFF_AUX_OV_EN: begin
          rdata_d = widen({10'h000, aux_ov_en_q});
        end
        ceaas_pkg::OFF_IRQ_STATUS: begin
          rdata_d = widen({11'h000, irq_status_q});
        end
        ceaas_pkg::OFF_IRQ_MASK: begin
          rdata_d = widen({11'h000, irq_mask_q});
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // Writes to the three status indices fall through: no write decode exists for them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule : ceaas_top

`default_nettype wire

// File: tb/ceaas_check_properties.sv
/*
  Port checker for the cell-extreme and aux alert status block.
  Assumes it is bound to ceaas_top and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module ceaas_check_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic scan_done,
  input wire logic scan_mode,
  input wire logic aux_acq_done,
  input wire logic [3:0] aux_over_rail,
  input wire logic [3:0] aux_switch_closed,
  input wire logic irq
);
  logic cfg_w;
  logic rd_now;

  assign cfg_w = clk_en && reg_wr && reg_addr == ceaas_pkg::OFF_AUX_PIN_CFG;
  assign rd_now = clk_en && reg_rd;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Register port
  a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_unmapped_zero: assert property (rd_now && reg_addr < 8'h0A |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_status_width: assert property (rd_now && (reg_addr == 8'h0B || reg_addr == 8'h0C) |=> reg_rdata[15:4] == 12'h000)
    else $error("status upper bits set");
  a_extreme_layout: assert property (rd_now && reg_addr == 8'h0A |=> (reg_rdata & 16'hF0F0) == 16'h0000)
    else $error("extreme word layout wrong");

  // ==========================================================
  // Aux protection
  a_fault_opens: assert property (clk_en && |aux_over_rail |=> (aux_switch_closed & $past(aux_over_rail)) == 4'h0)
    else $error("switch closed on over-rail pin");
  // Closing again needs a config rewrite, so a fault never self-heals
  a_close_after_cfg: assert property ((aux_switch_closed & ~$past(aux_switch_closed)) != 4'h0
    |-> $past(cfg_w) || $past(cfg_w, 2) || $past(cfg_w, 3))
    else $error("switch closed without config write");
  a_flag_hides_sw: assert property (rd_now && reg_addr == 8'h0B |=> (reg_rdata[3:0] & $past(aux_switch_closed)) == 4'h0)
    else $error("faulted pin switch closed");

  // ==========================================================
  // Interrupt
  // Aux causes reach irq one cycle later, through their flags
  a_irq_cause: assert property ($rose(irq) |-> $past(scan_done && scan_mode) || $past(|aux_over_rail, 2)
    || $past(aux_acq_done, 2) || $past(reg_wr))
    else $error("irq rose without cause");
  a_irq_holds: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("irq fell without write");

  c_scan: cover property (scan_done && scan_mode);
  c_fault: cover property (|aux_over_rail ##1 aux_switch_closed != 4'hF);
  c_reclose: cover property ($rose(aux_switch_closed[0]));
  c_irq: cover property ($fell(irq));

endmodule : ceaas_check_props

bind ceaas_top ceaas_check_props i_props (.core_clk, .rst, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .scan_done, .scan_mode, .aux_acq_done, .aux_over_rail, .aux_switch_closed, .irq);

`default_nettype wire

// File: tb/ceaas_host_model.sv
/*
  Host software model: register writes and reads on the plain port.
  Assumes the slave never stalls and answers reads one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none

module ceaas_host_model (
  input wire logic core_clk,
  input wire logic [15:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    reg_addr <= ~a;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd

endmodule : ceaas_host_model

`default_nettype wire

// File: tb/test_ceaas_top.sv
/*
  Self-checking bench for ceaas_top with the host model on the
  register port. Assumes clk_en is high except for one freeze check.
*/
`timescale 1ns/10ps
`default_nettype none

module test_ceaas_top;
  logic core_clk;
  logic rst;
  logic clk_en;
  logic scan_done;
  logic scan_mode;
  logic aux_acq_done;
  logic [3:0] aux_over_rail;
  logic [3:0] aux_over_threshold;
  logic [3:0] aux_switch_closed;
  logic irq;
  logic [223:0] cell_raw_data;
  logic [223:0] cell_iir_data;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  logic [15:0] raw [14];
  logic [15:0] iir [14];
  int err_total;
  int n_tests;

  ceaas_top i_dut (.core_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .scan_done, .scan_mode, .cell_raw_data, .cell_iir_data, .aux_acq_done, .aux_over_rail,
    .aux_over_threshold, .aux_switch_closed, .irq);
  ceaas_host_model i_host (.core_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    i_host.rd(a, rd_val);
    chk(rd_val, exp);
  endtask : rdc

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  task automatic scan(input logic mode);
    @(posedge core_clk);
    for (int k = 0; k < 14; k++) begin
      cell_raw_data[16*k +: 16] <= raw[k];
      cell_iir_data[16*k +: 16] <= iir[k];
    end
    scan_done <= 1'b1;
    scan_mode <= mode;
    @(posedge core_clk);
    scan_done <= 1'b0;
    cell_raw_data <= ~cell_raw_data;
    cell_iir_data <= ~cell_iir_data;
  endtask : scan

  task automatic acq(input logic [3:0] th);
    @(posedge core_clk);
    aux_over_threshold <= th;
    aux_acq_done <= 1'b1;
    @(posedge core_clk);
    aux_acq_done <= 1'b0;
    aux_over_threshold <= ~th;
  endtask : acq

  // ==========================================================
  // Scenarios
  task automatic t_reset_ro;
    for (int a = 10; a < 13; a++) begin
      rdc(8'(a), 16'h0000);
      i_host.wr(8'(a), 16'hFFFF);
      rdc(8'(a), 16'h0000);
    end
    rdc(8'h05, 16'h0000);
  endtask : t_reset_ro

  task automatic t_extremes;
    i_host.wr(ceaas_pkg::OFF_CELL_ENABLE, 16'h3FF7);
    for (int k = 0; k < 14; k++) begin
      raw[k] = 16'h0100 + 16'(k);
      iir[k] = 16'h0800 - 16'(k);
    end
    // Cell 4 is disabled but largest; ties on cells 5/10 and 3/7
    raw[3] = 16'hFFFF;
    raw[4] = 16'h0F00;
    raw[9] = 16'h0F00;
    raw[2] = 16'h0001;
    raw[6] = 16'h0001;
    scan(1'b1);
    rdc(ceaas_pkg::OFF_CELL_EXTREME, 16'h0503);
    i_host.wr(ceaas_pkg::OFF_SEARCH_CTRL, 16'h0001);
    scan(1'b1);
    rdc(ceaas_pkg::OFF_CELL_EXTREME, 16'h010E);
    iir[5] = 16'hFFFF;
    scan(1'b0);
    rdc(ceaas_pkg::OFF_CELL_EXTREME, 16'h010E);
    scan(1'b1);
    rdc(ceaas_pkg::OFF_CELL_EXTREME, 16'h060E);
  endtask : t_extremes

  task automatic t_polarity;
    i_host.wr(ceaas_pkg::OFF_CELL_ENABLE, 16'h3FFF);
    i_host.wr(ceaas_pkg::OFF_CELL_POLARITY, 16'h0090);
    i_host.wr(ceaas_pkg::OFF_SEARCH_CTRL, 16'h0002);
    for (int k = 0; k < 14; k++) begin
      raw[k] = 16'h0005;
    end
    raw[0] = 16'h0002;
    raw[4] = 16'hFF00;
    raw[7] = 16'h0010;
    scan(1'b1);
    rdc(ceaas_pkg::OFF_CELL_EXTREME, 16'h0805);
    i_host.wr(ceaas_pkg::OFF_SEARCH_CTRL, 16'h0000);
    scan(1'b1);
    rdc(ceaas_pkg::OFF_CELL_EXTREME, 16'h0201);
    i_host.wr(ceaas_pkg::OFF_CELL_POLARITY, 16'h0000);
    i_host.wr(ceaas_pkg::OFF_SEARCH_CTRL, 16'h0002);
    scan(1'b1);
    rdc(ceaas_pkg::OFF_CELL_EXTREME, 16'h0F0F);
  endtask : t_polarity

  task automatic rail(input logic [3:0] v);
    @(posedge core_clk);
    aux_over_rail <= v;
    idle(3);
  endtask : rail

  task automatic t_protect;
    i_host.wr(ceaas_pkg::OFF_IRQ_MASK, 16'h0002);
    i_host.wr(ceaas_pkg::OFF_AUX_PIN_CFG, 16'h0007);
    rail(4'h8);
    chk({12'h000, aux_switch_closed}, 16'h0007);
    chk({15'h0000, irq}, 16'h0000);
    rdc(ceaas_pkg::OFF_AUX_PROTECT, 16'h0000);
    rail(4'h1);
    chk({12'h000, aux_switch_closed}, 16'h0006);
    chk({15'h0000, irq}, 16'h0001);
    rail(4'h0);
    rdc(ceaas_pkg::OFF_AUX_PROTECT, 16'h0001);
    chk({12'h000, aux_switch_closed}, 16'h0006);
    rail(4'h1);
    i_host.wr(ceaas_pkg::OFF_AUX_PIN_CFG, 16'h0007);
    rail(4'h0);
    rdc(ceaas_pkg::OFF_AUX_PROTECT, 16'h0001);
    // Same value rewritten: only the write itself can trigger retry
    i_host.wr(ceaas_pkg::OFF_AUX_PIN_CFG, 16'h0007);
    idle(3);
    rdc(ceaas_pkg::OFF_AUX_PROTECT, 16'h0000);
    chk({12'h000, aux_switch_closed}, 16'h0007);
    rail(4'h4);
    rail(4'h0);
    rdc(ceaas_pkg::OFF_AUX_PROTECT, 16'h0004);
    i_host.wr(ceaas_pkg::OFF_AUX_PIN_CFG, 16'h0003);
    idle(3);
    rdc(ceaas_pkg::OFF_AUX_PROTECT, 16'h0000);
    i_host.wr(ceaas_pkg::OFF_IRQ_STATUS, 16'h0002);
    idle(1);
    chk({15'h0000, irq}, 16'h0000);
    i_host.wr(ceaas_pkg::OFF_IRQ_MASK, 16'h0001);
    idle(1);
    chk({15'h0000, irq}, 16'h0001);
  endtask : t_protect

  task automatic t_cold;
    i_host.wr(ceaas_pkg::OFF_AUX_PIN_CFG, 16'h000F);
    i_host.wr(ceaas_pkg::OFF_AUX_OV_EN, 16'h0005);
    acq(4'hF);
    rdc(ceaas_pkg::OFF_AUX_COLD, 16'h0005);
    acq(4'h1);
    rdc(ceaas_pkg::OFF_AUX_COLD, 16'h0001);
    acq(4'h0);
    rdc(ceaas_pkg::OFF_AUX_COLD, 16'h0000);
    // Acquisition while frozen must leave the flags alone
    @(posedge core_clk);
    clk_en <= 1'b0;
    acq(4'hF);
    clk_en <= 1'b1;
    rdc(ceaas_pkg::OFF_AUX_COLD, 16'h0000);
  endtask : t_cold

  // ==========================================================
  // Run control
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    scan_done = 1'b0;
    scan_mode = 1'b0;
    aux_acq_done = 1'b0;
    aux_over_rail = 4'h0;
    aux_over_threshold = 4'h0;
    cell_raw_data = 224'h0;
    cell_iir_data = 224'h0;
    err_total = 0;
    n_tests = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_ro();
    t_extremes();
    t_polarity();
    t_protect();
    t_cold();
    report_and_stop();
  end

endmodule : test_ceaas_top

`default_nettype wire
